// >>> hdl/sdf_pkg.sv
// shared constants and carriers for the slave diagnostic frame builder
package sdf_pkg;
    localparam int SDF_SLOTS = 12;
    localparam int SDF_MAX_MSG = 9;
    localparam int SDF_ADDR_BYTE = 3;
    localparam int SDF_ID_START = 6;
    localparam int SDF_ID_LEN = 3;
    localparam int SDF_MOD_LEN = 7;
    localparam int SDF_MOD_START = SDF_ID_START + SDF_ID_LEN;
    localparam int SDF_CH_START = SDF_MOD_START + SDF_MOD_LEN;
    localparam int SDF_MSG_LEN = 3;
    localparam logic [7:0] SDF_MAX_LEN_RST = 8'h3E;
    localparam logic [1:0] SDF_ST_OK = 2'b00;
    localparam logic [1:0] SDF_ST_MOD_ERR = 2'b01;
    localparam logic [1:0] SDF_ST_WRONG = 2'b10;
    localparam logic [1:0] SDF_ST_NO_MOD = 2'b11;
    localparam logic [7:0] SDF_ID_HDR = 8'h43;
    localparam logic [7:0] SDF_MOD_HDR0 = 8'h07;
    localparam logic [7:0] SDF_MOD_HDR1 = 8'h82;
    localparam logic [7:0] SDF_MOD_HDR2 = 8'h00;
    localparam logic [7:0] SDF_MOD_HDR3 = 8'h00;
    localparam logic [1:0] SDF_CH_HDR_TOP = 2'b10;

    typedef struct packed {
        logic [5:0] slot;
        logic power_mod;
        logic [5:0] channel;
        logic [7:0] error_type;
    } sdf_msg_s;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } sdf_beat_s;
endpackage

// >>> hdl/sdf_frame_builder.sv
// slave diagnostic frame builder: emits bytes 3 onward of the diagnostic frame as a byte stream
`timescale 1ns/1ps
`default_nettype none
module sdf_frame_builder
    import sdf_pkg::*;
#(
    parameter int SLOTS = SDF_SLOTS,
    parameter int MAX_MSG = SDF_MAX_MSG
)(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [6:0] master_addr_i,
    input wire logic [SLOTS-1:0] slot_fault_i,
    input wire logic [SLOTS-1:0] slot_missing_i,
    input wire logic [SLOTS-1:0] slot_wrong_i,
    input wire logic two_missing_i,
    input wire logic term_missing_i,
    input wire logic too_many_i,
    input wire logic bus_fault_i,
    input wire logic cause_found_i,
    input wire logic power_on_i,
    input wire logic chan_diag_en_i,
    input wire logic [7:0] max_len_i,
    input wire logic msg_valid_i,
    input wire sdf_msg_s msg_i,
    output logic msg_ready_o,
    input wire logic start_i,
    output logic busy_o,
    output logic invalid_cfg_o,
    output logic startup_ok_o,
    output logic data_exch_ok_o,
    output logic beat_valid_o,
    output sdf_beat_s beat_o,
    input wire logic beat_ready_i
);
    // ***********************************
    // reset release
    // ***********************************
    logic rst_q1_r, rst_n;
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_q1_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_q1_r <= 1'b1;
            rst_n <= rst_q1_r;
        end
    end

    // ***********************************
    // configuration checks
    // ***********************************
    logic fatal, gap_lock_r, power_on_d_r;
    assign fatal = two_missing_i | term_missing_i | too_many_i | bus_fault_i;
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_lock_r <= 1'b0;
            power_on_d_r <= 1'b0;
        end
        else
        begin
            power_on_d_r <= power_on_i;
            // a lone gap seen as power comes up keeps startup held
            if (power_on_i && !power_on_d_r)
                gap_lock_r <= |slot_missing_i;
        end
    end
    assign invalid_cfg_o = fatal;
    assign startup_ok_o = !fatal && !gap_lock_r;
    assign data_exch_ok_o = !fatal && !gap_lock_r;

    // ***********************************
    // channel message store, max nine
    // ***********************************
    sdf_msg_s store_r [MAX_MSG];
    logic [3:0] count_r;
    localparam logic [3:0] MAX_CNT = 4'(MAX_MSG);
    assign msg_ready_o = !busy_o;
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= 4'h0;
        else if (start_i && !busy_o)
            count_r <= 4'h0;
        else if (msg_valid_i && msg_ready_o && count_r < MAX_CNT)
            count_r <= count_r + 4'h1;
    end
    always_ff @(posedge clock_i)
    begin
        if (msg_valid_i && msg_ready_o && count_r < MAX_CNT && !start_i)
            store_r[count_r] <= msg_i;
    end

    // ***********************************
    // per-slot section contents
    // ***********************************
    logic [15:0] id_bits;
    logic [23:0] mod_bits;
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_id
            if (g < SLOTS)
            begin : g_use
                logic [1:0] st;
                // status comes from the fatal inputs, cause_found_i and the slot inputs, never from messages
                always_comb
                begin
                    if (fatal)
                        st = cause_found_i ? SDF_ST_NO_MOD : SDF_ST_MOD_ERR;
                    else if (slot_missing_i[g])
                        st = SDF_ST_NO_MOD;
                    else if (slot_wrong_i[g])
                        st = SDF_ST_WRONG;
                    else if (slot_fault_i[g])
                        st = SDF_ST_MOD_ERR;
                    else
                        st = SDF_ST_OK;
                end
                assign id_bits[g] = fatal | (st != SDF_ST_OK);
                assign mod_bits[2*g+1:2*g] = st;
            end
            else
            begin : g_pad
                assign id_bits[g] = 1'b0;
                if (g < 12)
                begin : g_mz
                    assign mod_bits[2*g+1:2*g] = 2'b00;
                end
            end
        end
    endgenerate

    // ***********************************
    // frame sequencer
    // ***********************************
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RUN = 2'b01
    } sdf_state_e;
    sdf_state_e state_r;
    logic [7:0] pos_r;
    logic [3:0] msg_n;
    logic [7:0] frame_len;
    logic [7:0] byte_v;
    logic push, buf_ready;
    sdf_msg_s cur;
    logic [7:0] rel;
    assign busy_o = (state_r == S_RUN);
    // message count trimmed so the frame stays within the length limit unless the limit is below the fixed sections
    always_comb
    begin
        msg_n = chan_diag_en_i ? count_r : 4'h0;
        frame_len = 8'(SDF_CH_START) + 8'(msg_n) * 8'(SDF_MSG_LEN);
        if (frame_len > max_len_i)
        begin
            // a limit below the fixed sections would wrap the subtraction, so no messages then
            msg_n = (max_len_i < 8'(SDF_CH_START)) ? 4'h0
                : 4'((max_len_i - 8'(SDF_CH_START)) / 8'(SDF_MSG_LEN));
            frame_len = 8'(SDF_CH_START) + 8'(msg_n) * 8'(SDF_MSG_LEN);
        end
    end
    always_comb
    begin
        rel = pos_r - 8'(SDF_CH_START);
        cur = store_r[4'(rel / 8'(SDF_MSG_LEN)) < MAX_CNT ? 4'(rel / 8'(SDF_MSG_LEN)) : 4'h0];
        byte_v = 8'h00;
        case (pos_r)
            8'(SDF_ADDR_BYTE): byte_v = {1'b0, master_addr_i};
            8'h04: byte_v = 8'h00;
            8'h05: byte_v = 8'h00;
            8'(SDF_ID_START): byte_v = SDF_ID_HDR;
            8'(SDF_ID_START+1): byte_v = id_bits[7:0];
            8'(SDF_ID_START+2): byte_v = {4'h0, id_bits[11:8]};
            8'(SDF_MOD_START): byte_v = SDF_MOD_HDR0;
            8'(SDF_MOD_START+1): byte_v = SDF_MOD_HDR1;
            8'(SDF_MOD_START+2): byte_v = SDF_MOD_HDR2;
            8'(SDF_MOD_START+3): byte_v = SDF_MOD_HDR3;
            8'(SDF_MOD_START+4): byte_v = mod_bits[7:0];
            8'(SDF_MOD_START+5): byte_v = mod_bits[15:8];
            8'(SDF_MOD_START+6): byte_v = mod_bits[23:16];
            default:
            begin
                case (rel % 8'(SDF_MSG_LEN))
                    8'h00: byte_v = {SDF_CH_HDR_TOP, cur.slot - 6'h01};
                    8'h01: byte_v = {cur.power_mod ? 2'b00 : 2'b11, cur.channel};
                    default: byte_v = cur.error_type;
                endcase
            end
        endcase
    end
    assign push = (state_r == S_RUN) && buf_ready;
    logic [7:0] len_r;
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= S_IDLE;
            pos_r <= 8'h00;
            len_r <= 8'h00;
        end
        else
        begin
            case (state_r)
                S_IDLE:
                    if (start_i)
                    begin
                        state_r <= S_RUN;
                        pos_r <= 8'(SDF_ADDR_BYTE);
                        len_r <= frame_len;
                    end
                S_RUN:
                    if (push)
                    begin
                        pos_r <= pos_r + 8'h01;
                        if (pos_r == len_r - 8'h01)
                            state_r <= S_IDLE;
                    end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // ***********************************
    // two-entry output buffer
    // ***********************************
    // holds up to two bytes and pauses the sequencer when full, so no byte is lost however long the reader stops
    sdf_beat_s buf_r [2];
    logic [1:0] fill_r;
    logic pop;
    assign buf_ready = (fill_r != 2'h2);
    assign pop = beat_valid_o && beat_ready_i;
    assign beat_valid_o = (fill_r != 2'h0);
    assign beat_o = buf_r[0];
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fill_r <= 2'h0;
            buf_r[0] <= '0;
            buf_r[1] <= '0;
        end
        else
        begin
            if (pop)
                buf_r[0] <= buf_r[1];
            if (push)
            begin
                if (fill_r == 2'h0 || (fill_r == 2'h1 && pop))
                    buf_r[0] <= '{data: byte_v, last: pos_r == len_r - 8'h01};
                else
                    buf_r[1] <= '{data: byte_v, last: pos_r == len_r - 8'h01};
            end
            fill_r <= fill_r + 2'(push) - 2'(pop);
        end
    end

    // ***********************************
    // checks
    // ***********************************
    fatal_blocks_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        fatal |-> !data_exch_ok_o && !startup_ok_o) else $error("fatal config allowed data exchange");
    msg_cap_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        count_r <= MAX_CNT) else $error("more than nine messages held");
    len_cap_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        busy_o |-> len_r <= max_len_i || len_r == 8'(SDF_CH_START)) else $error("frame over length");
    all_ids_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        fatal |-> id_bits[11:0] == 12'hFFF) else $error("invalid config ids not all set");
    id_start_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        push && pos_r == 8'(SDF_ID_START) |-> byte_v == SDF_ID_HDR) else $error("id section misplaced");
    addr_byte_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        push && pos_r == 8'(SDF_ADDR_BYTE) |-> byte_v[6:0] == master_addr_i) else $error("bad master address");
    buf_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        beat_valid_o && !beat_ready_i |=> beat_valid_o && $stable(beat_o)) else $error("buffer lost a byte");
    gap_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        gap_lock_r |-> !startup_ok_o) else $error("startup with gap");
endmodule
`default_nettype wire

// >>> sim/sdf_sink_model.sv
// stream sink standing in for the master that reads the diagnostic frame
`timescale 1ns/1ps
`default_nettype none
module sdf_sink_model
    import sdf_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic beat_valid_i,
    input wire sdf_beat_s beat_i,
    output logic beat_ready_o
);
    int seed = 50677;
    // ****************
    // ready pattern
    // ****************
    // random stalls of a few cycles fill the two-entry buffer and then drain it
    always @(posedge clock_i or negedge resetn_i)
        if (!resetn_i)
            beat_ready_o <= 1'b0;
        else
            beat_ready_o <= ({$random(seed)} % 3) != 0;
endmodule
`default_nettype wire

// >>> sim/sdf_frame_builder_bench.sv
// self-checking bench for the diagnostic frame builder
`timescale 1ns/1ps
`default_nettype none
module sdf_frame_builder_bench;
    import sdf_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n = 1'b0, pon = 1'b0, cf = 1'b0, en = 1'b0, mv = 1'b0, st = 1'b0;
    logic [3:0] fat = 4'h0;
    logic [6:0] addr = 7'h00;
    logic [11:0] flt = 12'h000, mis = 12'h000, wrg = 12'h000;
    logic [7:0] ml = 8'h3E;
    sdf_msg_s msg = '0;
    sdf_msg_s store [$];
    sdf_beat_s beat;
    logic rdy, bv, mr, busy, inv, sok, dok;
    logic [8:0] expq [$];
    int failures = 0, tests_run = 0, seed = 50677, k;
    always #10 clock_i = ~clock_i;
    sdf_frame_builder dut (.clock_i(clock_i), .resetn_i(rst_n), .master_addr_i(addr), .slot_fault_i(flt),
        .slot_missing_i(mis), .slot_wrong_i(wrg), .two_missing_i(fat[0]), .term_missing_i(fat[1]),
        .too_many_i(fat[2]), .bus_fault_i(fat[3]), .cause_found_i(cf), .power_on_i(pon), .chan_diag_en_i(en),
        .max_len_i(ml), .msg_valid_i(mv), .msg_i(msg), .msg_ready_o(mr), .start_i(st), .busy_o(busy),
        .invalid_cfg_o(inv), .startup_ok_o(sok), .data_exch_ok_o(dok), .beat_valid_o(bv), .beat_o(beat),
        .beat_ready_i(rdy));
    sdf_sink_model sink (.clock_i(clock_i), .resetn_i(rst_n), .beat_valid_i(bv), .beat_i(beat), .beat_ready_o(rdy));
    // ****************
    // checking
    // ****************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge clock_i)
        if (bv === 1'b1 && rdy === 1'b1)
        begin
            if (expq.size() == 0)
                chk("extra byte", {7'h00, beat}, 16'hFFFF);
            else
                chk("frame byte", {7'h00, beat}, {7'h00, expq.pop_front()});
        end
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ****************
    // stimulus
    // ****************
    task automatic put_msgs(input int n);
        sdf_msg_s m;
        repeat (n)
        begin
            m = sdf_msg_s'(21'($random(seed)));
            m.slot = 6'(1 + {$random(seed)} % SDF_SLOTS);
            store.push_back(m);
            msg <= m;
            mv <= 1'b1;
            @(posedge clock_i);
            chk("ready when idle", mr, 16'h0001);
        end
        mv <= 1'b0;
    endtask
    // expected frame worked out from the inputs; first messages win when trimmed
    task automatic run(input int n, input logic [7:0] maxlen);
        logic [7:0] b [$];
        logic [11:0] ids;
        logic [23:0] sts;
        int keep;
        store = {};
        ml <= maxlen;
        put_msgs(n);
        for (int i = 0; i < SDF_SLOTS; i++)
        begin
            ids[i] = |fat | flt[i] | mis[i] | wrg[i];
            sts[2*i +: 2] = |fat ? (cf ? SDF_ST_NO_MOD : SDF_ST_MOD_ERR) : mis[i] ? SDF_ST_NO_MOD :
                wrg[i] ? SDF_ST_WRONG : flt[i] ? SDF_ST_MOD_ERR : SDF_ST_OK;
        end
        keep = (maxlen < 16 || !en) ? 0 : (maxlen - 16) / 3;
        if (keep > store.size())
            keep = store.size();
        if (keep > SDF_MAX_MSG)
            keep = SDF_MAX_MSG;
        b = '{{1'b0, addr}, 8'h00, 8'h00, SDF_ID_HDR, ids[7:0], {4'h0, ids[11:8]}, SDF_MOD_HDR0, SDF_MOD_HDR1,
            SDF_MOD_HDR2, SDF_MOD_HDR3, sts[7:0], sts[15:8], sts[23:16]};
        for (int i = 0; i < keep; i++)
        begin
            b.push_back({SDF_CH_HDR_TOP, store[i].slot - 6'h01});
            b.push_back({store[i].power_mod ? 2'b00 : 2'b11, store[i].channel});
            b.push_back(store[i].error_type);
        end
        foreach (b[i])
            expq.push_back({b[i], i == b.size() - 1});
        st <= 1'b1;
        @(posedge clock_i);
        st <= 1'b0;
        for (int t = 0; t < 600 && (expq.size() != 0 || busy !== 1'b0); t++)
        begin
            @(posedge clock_i);
            if (t == 0)
                chk("ready while busy", mr, 16'h0000);
        end
        chk("bytes left", 16'(expq.size()), 16'h0000);
        $display("frame of %0d bytes ended", b.size());
    endtask
    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock_i);
        pon <= 1'b1;
        addr <= 7'($random(seed));
        repeat (3) @(posedge clock_i);
        run(0, 8'h3E);
        chk("clean invalid", inv, 16'h0000);
        chk("clean exchange", dok, 16'h0001);
        for (int i = 0; i < SDF_SLOTS; i++)
        begin
            k = {$random(seed)} % 4;
            {mis[i], wrg[i], flt[i]} <= 3'((4'b0001 << k) >> 1);
        end
        en <= 1'b1;
        @(posedge clock_i);
        run(4, 8'h3E);
        run(11, 8'h3E);
        run(5, 8'h1E);
        run(3, 8'h0A);
        en <= 1'b0;
        @(posedge clock_i);
        run(4, 8'h3E);
        en <= 1'b1;
        for (int f = 0; f < 8; f++)
        begin
            fat <= 4'(1 << (f % 4));
            cf <= f[2];
            repeat (2) @(posedge clock_i);
            chk("invalid flag", inv, 16'h0001);
            chk("exchange blocked", dok, 16'h0000);
            run(2, 8'h3E);
        end
        fat <= 4'h0;
        cf <= 1'b0;
        {flt, wrg, pon} <= '0;
        mis <= 12'h010;
        repeat (2) @(posedge clock_i);
        pon <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("startup with gap", sok, 16'h0000);
        mis <= 12'h000;
        pon <= 1'b0;
        repeat (2) @(posedge clock_i);
        pon <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("startup clean", sok, 16'h0001);
        $display("startup checks ended");
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
